// ===== tsbg_top.sv
// Timers 0, 1 and 2 with serial baud clock selection behind an AXI4-Lite slave
// Summary of operation
// RULE1: timers 0/1 modes: 13-bit prescaled, 16-bit, 8-bit auto-reload, split.
// RULE2: split mode: timer 0 gives two 8-bit timers, timer 1 halts.
// RULE3: timer function increments once per 12-clock machine cycle.
// RULE4: counter function increments on a sampled falling edge of its count pin.
// RULE5: edge detection spans two machine cycles; source must not toggle faster.
// RULE6: with gating on, timer 0/1 counts only while its interrupt pin is high.
// RULE7: timer 2 counts machine cycles or count-pin edges per count select; as baud source the code counts half clocks instead of machine cycles.
// RULE8: timer 2 is 16 bits; up/down follows the external pin when enabled.
// RULE9: timer 2 runs as baud source, auto-reload or capture; stops when not run.
// RULE10: reload on overflow or external edge; capture copies count on that edge.
// RULE11: baud mode sets no overflow flag; external edge still raises a request.
// RULE12: serial mode 0 is synchronous with shift clock at oscillator over 12.
// RULE13: serial mode 1 is 10-bit frames clocked from timer 1, timer 2 or generator.
// RULE14: serial mode 2 is 11-bit frames at oscillator over 64, or 32 doubled.
// RULE15: serial mode 3 frames like mode 2 with the variable baud source.
// RULE16: timer 1 source divides overflows by 32 or 16; timer 2 by 16.
// RULE17: baud generator is a free 10-bit timer at half clock with reload.
// RULE18: baud generator feeds the serial port only while its select bit is set.
`timescale 1ns/10ps
module tsbg_top
  import tsbg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins
  input  wire tsbg_pins_t        pins,
  // Serial clocking and interrupt
  output tsbg_baud_t             baud,
  output logic                   irq
);
  `include "tsbg_consts.svh"

  if (ADDR_W < 8) begin : g_chk
    $error("tsbg_top needs an address of at least 8 bits");
  end

  tsbg_state_t q;
  tsbg_state_t n;
  logic [5:0]  lvl;
  tsbg_pins_t  pl;

  tsbg_sync #(
    .W (6)
  ) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .din    (pins),
    .lvl    (lvl)
  );
  assign pl = tsbg_pins_t'(lvl);

  function automatic tsbg_tmr_t tmr_step(input logic [1:0] md, input logic [7:0] tl,
                                         input logic [7:0] th, input logic inc);
    tmr_step = '{tl: tl, th: th, ovf: 1'b0};
    if (inc) begin
      case (md)
        2'b00: {tmr_step.ovf, tmr_step.th, tmr_step.tl[4:0]} = {1'b0, th, tl[4:0]} + 14'h0001;
        2'b01: {tmr_step.ovf, tmr_step.th, tmr_step.tl} = {1'b0, th, tl} + 17'h00001;
        2'b10: begin
          if (tl == 8'hFF) begin
            tmr_step.tl  = th;
            tmr_step.ovf = 1'b1;
          end else begin
            tmr_step.tl = tl + 8'h01;
          end
        end
        default: {tmr_step.ovf, tmr_step.tl} = {1'b0, tl} + 9'h001;
      endcase
    end
  endfunction : tmr_step

  // Returns {tick, next prescale}; /16 or /32 of the source pulses
  function automatic logic [5:0] bdiv(input logic [4:0] p, input logic src,
                                      input logic div16);
    bdiv = {1'b0, p};
    if (src) begin
      if (div16 ? (p[3:0] == 4'hF) : (p == 5'h1F)) begin
        bdiv = {1'b1, 5'h00};
      end else begin
        bdiv = {1'b0, p + 5'h01};
      end
    end
  endfunction : bdiv

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : wr16

  logic        mc_tick;
  logic        half_tick;
  logic        f_t0;
  logic        f_t1;
  logic        f_t2;
  logic        f_ex;
  logic        inc0;
  logic        inc1;
  logic        th0_ovf;
  logic        t1_ovf;
  logic        t2_src;
  logic        t2_ovf;
  logic        baud2;
  logic        brg_ovf;
  logic        wr_go;
  logic        rd_go;
  logic [3:0]  ev;
  logic [3:0]  clr;
  logic [5:0]  rxr;
  logic [5:0]  txr;
  tsbg_tmr_t   r0;
  tsbg_tmr_t   r1;
  tsbg_smode_t smode;

  always_comb begin
    n         = q;
    ev        = 4'h0;
    clr       = 4'h0;
    th0_ovf   = 1'b0;
    t2_ovf    = 1'b0;
    brg_ovf   = 1'b0;
    // Machine cycle of 12 clocks and the half-rate tick
    mc_tick   = (q.mc == `TSBG_MC_LAST);                                          // [RULE3]
    n.mc      = mc_tick ? 4'h0 : q.mc + 4'h1;
    half_tick = q.half;
    n.half    = ~q.half;
    // Pins sampled once a machine cycle, so an edge needs two samples
    if (mc_tick) begin
      n.smp = {pl.count_input_zero, pl.count_input_one, pl.aux_count_pin, pl.aux_ext_pin};
    end
    f_t0 = mc_tick & q.smp[3] & ~pl.count_input_zero;                             // [RULE4] [RULE5]
    f_t1 = mc_tick & q.smp[2] & ~pl.count_input_one;                              // [RULE4] [RULE5]
    f_t2 = mc_tick & q.smp[1] & ~pl.aux_count_pin;                                // [RULE7]
    f_ex = mc_tick & q.smp[0] & ~pl.aux_ext_pin;
    // Timers 0 and 1
    inc0 = q.run01[`TSBG_RUN0] & (~q.mode01[`TSBG_TM_GATE0] | pl.ext_irq_zero_pin)   // [RULE6]
         & (q.mode01[`TSBG_TM_CT0] ? f_t0 : mc_tick);                             // [RULE3]
    inc1 = q.run01[`TSBG_RUN1] & (~q.mode01[`TSBG_TM_GATE1] | pl.ext_irq_one_pin)    // [RULE6]
         & (q.mode01[`TSBG_TM_CT1] ? f_t1 : mc_tick)
         & (q.mode01[`TSBG_TM_MODE1_LO +: 2] != 2'b11);                           // [RULE2]
    r0 = tmr_step(q.mode01[`TSBG_TM_MODE0_LO +: 2], q.tl0, q.th0, inc0);          // [RULE1]
    r1 = tmr_step(q.mode01[`TSBG_TM_MODE1_LO +: 2], q.tl1, q.th1, inc1);          // [RULE1]
    n.tl0 = r0.tl;
    n.th0 = r0.th;
    n.tl1 = r1.tl;
    n.th1 = r1.th;
    t1_ovf = r1.ovf;
    // Split mode: the high byte runs as a plain timer on timer 1's run bit
    if (q.mode01[`TSBG_TM_MODE0_LO +: 2] == 2'b11 && mc_tick && q.run01[`TSBG_RUN1]) begin  // [RULE2]
      {th0_ovf, n.th0} = {1'b0, q.th0} + 9'h001;
    end
    ev[`TSBG_ST_TF0] = r0.ovf;
    ev[`TSBG_ST_TF1] = (q.mode01[`TSBG_TM_MODE0_LO +: 2] == 2'b11) ? th0_ovf : r1.ovf;
    // Timer 2
    baud2  = q.auxctl[`TSBG_A2_RXAUX] | q.auxctl[`TSBG_A2_TXAUX];
    t2_src = q.auxctl[`TSBG_A2_CT] ? f_t2 : (baud2 ? half_tick : mc_tick);        // [RULE7]
    if (q.auxctl[`TSBG_A2_RUN]) begin                                             // [RULE9]
      if (baud2) begin
        if (t2_src) begin
          t2_ovf = (q.cnt2 == 16'hFFFF);
          n.cnt2 = t2_ovf ? q.rc2 : q.cnt2 + 16'h0001;
        end
        ev[`TSBG_ST_EXF2] = q.auxctl[`TSBG_A2_EXEN] & f_ex;                       // [RULE11]
      end else if (q.auxctl[`TSBG_A2_CPRL]) begin
        if (t2_src) begin
          t2_ovf = (q.cnt2 == 16'hFFFF);
          n.cnt2 = q.cnt2 + 16'h0001;
        end
        if (q.auxctl[`TSBG_A2_EXEN] && f_ex) begin
          n.rc2 = q.cnt2;                                                         // [RULE10]
          ev[`TSBG_ST_EXF2] = 1'b1;
        end
      end else if (q.updown_enable) begin
        if (t2_src && pl.aux_ext_pin) begin                                       // [RULE8]
          t2_ovf = (q.cnt2 == 16'hFFFF);
          n.cnt2 = t2_ovf ? q.rc2 : q.cnt2 + 16'h0001;
        end else if (t2_src) begin
          t2_ovf = (q.cnt2 == q.rc2);
          n.cnt2 = t2_ovf ? 16'hFFFF : q.cnt2 - 16'h0001;
        end
      end else begin
        if (t2_src) begin
          t2_ovf = (q.cnt2 == 16'hFFFF);
        end
        if (t2_ovf || (q.auxctl[`TSBG_A2_EXEN] && f_ex)) begin
          n.cnt2 = q.rc2;                                                         // [RULE10]
        end else if (t2_src) begin
          n.cnt2 = q.cnt2 + 16'h0001;
        end
        ev[`TSBG_ST_EXF2] = q.auxctl[`TSBG_A2_EXEN] & f_ex;
      end
    end
    ev[`TSBG_ST_TF2] = t2_ovf & ~baud2;                                           // [RULE11]
    // Free-running baud generator at half clock
    if (half_tick) begin                                                          // [RULE17]
      brg_ovf = (q.brg == 10'h3FF);
      n.brg   = brg_ovf ? q.brg_reload : q.brg + 10'h001;
    end
    // Serial baud selection
    case (q.serial[`TSBG_SR_MODE_LO +: 2])
      2'b00:   smode = TSBG_SER_SYNC;
      2'b01:   smode = TSBG_SER_UART8;
      2'b10:   smode = TSBG_SER_FIX9;
      default: smode = TSBG_SER_VAR9;
    endcase
    rxr = bdiv(q.rxp, q.auxctl[`TSBG_A2_RXAUX] ? t2_ovf
                     : (q.serial[`TSBG_SR_BRGSEL] ? brg_ovf : t1_ovf),            // [RULE18]
               q.auxctl[`TSBG_A2_RXAUX] | q.serial[`TSBG_SR_DOUBLE]);             // [RULE16]
    txr = bdiv(q.txp, q.auxctl[`TSBG_A2_TXAUX] ? t2_ovf
                     : (q.serial[`TSBG_SR_BRGSEL] ? brg_ovf : t1_ovf),            // [RULE18]
               q.auxctl[`TSBG_A2_TXAUX] | q.serial[`TSBG_SR_DOUBLE]);             // [RULE16]
    n.baud.shift_clk = 1'b0;
    case (smode)
      TSBG_SER_SYNC: begin                                                        // [RULE12]
        n.baud.rx_tick    = mc_tick;
        n.baud.tx_tick    = mc_tick;
        n.baud.shift_clk  = (n.mc >= `TSBG_SHCLK_HI);
        n.baud.frame_bits = `TSBG_FRAME_SYNC;
        n.rxp             = 5'h00;
        n.txp             = 5'h00;
      end
      TSBG_SER_FIX9: begin                                                        // [RULE14]
        rxr               = bdiv(q.rxp, half_tick, q.serial[`TSBG_SR_DOUBLE]);
        n.baud.rx_tick    = rxr[5];
        n.baud.tx_tick    = rxr[5];
        n.baud.frame_bits = `TSBG_FRAME_UART9;
        n.rxp             = rxr[4:0];
        n.txp             = 5'h00;
      end
      default: begin                                                              // [RULE13] [RULE15]
        n.baud.rx_tick    = rxr[5];
        n.baud.tx_tick    = txr[5];
        n.baud.frame_bits = (smode == TSBG_SER_UART8) ? `TSBG_FRAME_UART8 : `TSBG_FRAME_UART9;
        n.rxp             = rxr[4:0];
        n.txp             = txr[4:0];
      end
    endcase
    // AXI4-Lite write: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_ok  = 1'b1;
      n.aw_a   = s_axi_awaddr[7:0];
      n.aw_bad = (s_axi_awaddr >> 8) != '0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_ok = 1'b1;
      n.w_d  = s_axi_wdata;
      n.w_s  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // Software write overrides the hardware update of the same register
    wr_go = q.aw_ok & q.w_ok;
    if (wr_go) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = `TSBG_RESP_OK;
      if (q.aw_bad) begin
        n.bresp = `TSBG_RESP_ERR;
      end else if (q.aw_a == `TSBG_OFS_MODE01) begin
        n.mode01 = q.w_s[0] ? q.w_d[7:0] : q.mode01;
      end else if (q.aw_a == `TSBG_OFS_RUN01) begin
        n.run01 = q.w_s[0] ? q.w_d[1:0] : q.run01;
      end else if (q.aw_a == `TSBG_OFS_CNT0) begin
        {n.th0, n.tl0} = wr16({q.th0, q.tl0}, q.w_d, q.w_s);
      end else if (q.aw_a == `TSBG_OFS_CNT1) begin
        {n.th1, n.tl1} = wr16({q.th1, q.tl1}, q.w_d, q.w_s);
      end else if (q.aw_a == `TSBG_OFS_AUXCTL) begin
        n.auxctl = q.w_s[0] ? q.w_d[5:0] : q.auxctl;
      end else if (q.aw_a == `TSBG_OFS_AUXMODE) begin
        n.updown_enable = q.w_s[0] ? q.w_d[0] : q.updown_enable;
      end else if (q.aw_a == `TSBG_OFS_RELOAD2) begin
        n.rc2 = wr16(q.rc2, q.w_d, q.w_s);
      end else if (q.aw_a == `TSBG_OFS_CNT2) begin
        n.cnt2 = wr16(q.cnt2, q.w_d, q.w_s);
      end else if (q.aw_a == `TSBG_OFS_SERIAL) begin
        n.serial = q.w_s[0] ? q.w_d[3:0] : q.serial;
      end else if (q.aw_a == `TSBG_OFS_BRG) begin
        n.brg_reload = 10'(wr16({6'h00, q.brg_reload}, q.w_d, q.w_s));
      end else if (q.aw_a == `TSBG_OFS_MASK) begin
        n.mask = q.w_s[0] ? q.w_d[3:0] : q.mask;
      end else if (q.aw_a != `TSBG_OFS_STAT) begin
        n.bresp = `TSBG_RESP_ERR;
      end
    end
    // AXI4-Lite read; status clears on read but a new event still sets
    rd_go = s_axi_arvalid & s_axi_arready;
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rresp  = `TSBG_RESP_OK;
      n.rdata  = 32'h0000_0000;
      if ((s_axi_araddr >> 8) != '0) begin
        n.rresp = `TSBG_RESP_ERR;
      end else if (s_axi_araddr[7:0] == `TSBG_OFS_MODE01) begin
        n.rdata[7:0] = q.mode01;
      end else if (s_axi_araddr[7:0] == `TSBG_OFS_RUN01) begin
        n.rdata[1:0] = q.run01;
      end else if (s_axi_araddr[7:0] == `TSBG_OFS_CNT0) begin
        n.rdata[15:0] = {q.th0, q.tl0};
      end else if (s_axi_araddr[7:0] == `TSBG_OFS_CNT1) begin
        n.rdata[15:0] = {q.th1, q.tl1};
      end else if (s_axi_araddr[7:0] == `TSBG_OFS_AUXCTL) begin
        n.rdata[5:0] = q.auxctl;
      end else if (s_axi_araddr[7:0] == `TSBG_OFS_AUXMODE) begin
        n.rdata[0] = q.updown_enable;
      end else if (s_axi_araddr[7:0] == `TSBG_OFS_RELOAD2) begin
        n.rdata[15:0] = q.rc2;
      end else if (s_axi_araddr[7:0] == `TSBG_OFS_CNT2) begin
        n.rdata[15:0] = q.cnt2;
      end else if (s_axi_araddr[7:0] == `TSBG_OFS_SERIAL) begin
        n.rdata[3:0] = q.serial;
      end else if (s_axi_araddr[7:0] == `TSBG_OFS_BRG) begin
        n.rdata[9:0] = q.brg_reload;
      end else if (s_axi_araddr[7:0] == `TSBG_OFS_STAT) begin
        n.rdata[3:0] = q.stat;
        clr          = q.stat;
      end else if (s_axi_araddr[7:0] == `TSBG_OFS_MASK) begin
        n.rdata[3:0] = q.mask;
      end else begin
        n.rresp = `TSBG_RESP_ERR;
      end
    end
    n.stat = (q.stat & ~clr) | ev;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = ~q.aw_ok & ~q.bvalid;
  assign s_axi_wready  = ~q.w_ok & ~q.bvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign baud          = q.baud;
  assign irq           = |(q.stat & q.mask);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_quiet_mc;
    !mc_tick [*8];
  endsequence

  a_mc_period: assert property (mc_tick |=> s_quiet_mc ##1 !mc_tick [*3] ##1 mc_tick)  // [RULE3]
    else $error("machine cycle is not 12 clocks");
  a_t0_timer_inc: assert property (
    q.mode01[1:0] == 2'b01 && !q.mode01[`TSBG_TM_CT0] && !q.mode01[`TSBG_TM_GATE0]
    && q.run01[0] && mc_tick && !wr_go |=> {q.th0, q.tl0} == $past({q.th0, q.tl0}) + 16'h0001)  // [RULE3]
    else $error("timer 0 missed its machine-cycle increment");
  a_gate_holds: assert property (
    q.mode01[`TSBG_TM_GATE0] && !pl.ext_irq_zero_pin && q.mode01[1:0] != 2'b11 && !wr_go
    |=> $stable(q.tl0) && $stable(q.th0))  // [RULE6]
    else $error("gated timer 0 counted with its gate low");
  a_t1_halted: assert property (q.mode01[5:4] == 2'b11 && !wr_go |=> $stable({q.th1, q.tl1}))  // [RULE2]
    else $error("timer 1 counted in split mode");
  a_edge_on_mc: assert property ((f_t0 || f_t1 || f_t2) |-> mc_tick && $past(mc_tick, 12))  // [RULE5]
    else $error("count edge outside machine-cycle sampling");
  a_t2_stopped: assert property (!q.auxctl[`TSBG_A2_RUN] && !wr_go |=> $stable(q.cnt2))  // [RULE9]
    else $error("timer 2 moved while stopped");
  a_baud_no_tf2: assert property (baud2 && !q.stat[`TSBG_ST_TF2] |=> !q.stat[`TSBG_ST_TF2])  // [RULE11]
    else $error("overflow flag set in baud mode");
  a_t2_reload: assert property (
    q.auxctl[`TSBG_A2_RUN] && !baud2 && !q.auxctl[`TSBG_A2_CPRL] && !q.updown_enable
    && t2_ovf && !wr_go |=> q.cnt2 == $past(q.rc2))  // [RULE10]
    else $error("timer 2 did not reload on overflow");
  a_t2_down: assert property (
    q.auxctl[`TSBG_A2_RUN] && !baud2 && !q.auxctl[`TSBG_A2_CPRL] && q.updown_enable
    && !pl.aux_ext_pin && t2_src && q.cnt2 != q.rc2 && !wr_go
    |=> q.cnt2 == $past(q.cnt2) - 16'h0001)  // [RULE8]
    else $error("timer 2 did not count down");
  a_mode2_rate: assert property (
    $past(smode == TSBG_SER_FIX9) && !q.serial[`TSBG_SR_DOUBLE] && q.baud.tx_tick && !wr_go
    |=> !q.baud.tx_tick [*8] ##1 !q.baud.tx_tick [*8])  // [RULE14]
    else $error("fixed-rate serial tick too fast");
  a_stat_clear: assert property (rd_go && s_axi_araddr == ADDR_W'(`TSBG_OFS_STAT) && ev == 4'h0
    |=> q.stat == 4'h0)
    else $error("status not cleared by read");
endmodule : tsbg_top

// ===== tsbg_consts.svh
// Register offsets, field positions, reset values and timing counts of the timer block
`ifndef TSBG_CONSTS_SVH
`define TSBG_CONSTS_SVH
`define TSBG_OFS_MODE01   8'h00
`define TSBG_OFS_RUN01    8'h04
`define TSBG_OFS_CNT0     8'h08
`define TSBG_OFS_CNT1     8'h0C
`define TSBG_OFS_AUXCTL   8'h10
`define TSBG_OFS_AUXMODE  8'h14
`define TSBG_OFS_RELOAD2  8'h18
`define TSBG_OFS_CNT2     8'h1C
`define TSBG_OFS_SERIAL   8'h20
`define TSBG_OFS_BRG      8'h24
`define TSBG_OFS_STAT     8'h28
`define TSBG_OFS_MASK     8'h2C
`define TSBG_TM_MODE0_LO  0
`define TSBG_TM_CT0       2
`define TSBG_TM_GATE0     3
`define TSBG_TM_MODE1_LO  4
`define TSBG_TM_CT1       6
`define TSBG_TM_GATE1     7
`define TSBG_RUN0         0
`define TSBG_RUN1         1
`define TSBG_A2_CPRL      0
`define TSBG_A2_CT        1
`define TSBG_A2_RUN       2
`define TSBG_A2_EXEN      3
`define TSBG_A2_TXAUX     4
`define TSBG_A2_RXAUX     5
`define TSBG_SR_MODE_LO   0
`define TSBG_SR_DOUBLE    2
`define TSBG_SR_BRGSEL    3
`define TSBG_ST_TF0       0
`define TSBG_ST_TF1       1
`define TSBG_ST_TF2       2
`define TSBG_ST_EXF2      3
`define TSBG_RST_WORD     16'h0000
`define TSBG_RST_PIN      1'b1
`define TSBG_MC_CLKS      12
`define TSBG_MC_LAST      4'hB
`define TSBG_SHCLK_HI     4'h6
`define TSBG_FRAME_SYNC   4'h8
`define TSBG_FRAME_UART8  4'hA
`define TSBG_FRAME_UART9  4'hB
`define TSBG_RESP_OK      2'h0
`define TSBG_RESP_ERR     2'h2
`endif

// ===== tsbg_pkg.sv
// Types shared by the timer and baud block
package tsbg_pkg;
  typedef struct packed {
    logic ext_irq_zero_pin;
    logic ext_irq_one_pin;
    logic count_input_zero;
    logic count_input_one;
    logic aux_count_pin;
    logic aux_ext_pin;
  } tsbg_pins_t;
  typedef struct packed {
    logic       rx_tick;
    logic       tx_tick;
    logic       shift_clk;
    logic [3:0] frame_bits;
  } tsbg_baud_t;
  typedef struct packed {
    logic [7:0] tl;
    logic [7:0] th;
    logic       ovf;
  } tsbg_tmr_t;
  typedef enum logic [3:0] {
    TSBG_SER_SYNC  = 4'b0001,
    TSBG_SER_UART8 = 4'b0010,
    TSBG_SER_FIX9  = 4'b0100,
    TSBG_SER_VAR9  = 4'b1000
  } tsbg_smode_t;
  typedef struct packed {
    logic [7:0]  mode01;
    logic [1:0]  run01;
    logic [7:0]  tl0;
    logic [7:0]  th0;
    logic [7:0]  tl1;
    logic [7:0]  th1;
    logic [5:0]  auxctl;
    logic        updown_enable;
    logic [15:0] rc2;
    logic [15:0] cnt2;
    logic [3:0]  serial;
    logic [9:0]  brg_reload;
    logic [9:0]  brg;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic [3:0]  mc;
    logic        half;
    logic [3:0]  smp;
    logic [4:0]  rxp;
    logic [4:0]  txp;
    tsbg_baud_t  baud;
    logic        aw_ok;
    logic        aw_bad;
    logic [7:0]  aw_a;
    logic        w_ok;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tsbg_state_t;
endpackage : tsbg_pkg

// ===== tsbg_sync.sv
// Three-stage pin synchroniser; a level is taken once stages two and three agree
`timescale 1ns/10ps
module tsbg_sync #(
  parameter int W = 6
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         arst_n,
  // Pins in, clean levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] lvl
);
  `include "tsbg_consts.svh"
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lv;
  } tsbg_sync_t;

  tsbg_sync_t q;
  tsbg_sync_t n;

  if (W < 1) begin : g_chk
    $error("tsbg_sync needs at least one bit");
  end

  always_comb begin
    n    = q;
    n.s1 = din;
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.lv[i] = q.s3[i];
      end
    end
  end

  // Pins idle high so no false falling edge follows reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{s1: {W{`TSBG_RST_PIN}}, s2: {W{`TSBG_RST_PIN}},
             s3: {W{`TSBG_RST_PIN}}, lv: {W{`TSBG_RST_PIN}}};
    end else begin
      q <= n;
    end
  end

  assign lvl = q.lv;
endmodule : tsbg_sync

// ===== tsbg_pin_model.sv
// Pin-side partner: count, gate and trigger pins
`timescale 1ns/10ps
module tsbg_pin_model
  import tsbg_pkg::*;
(
  // Clock
  input  wire logic       mclk,
  // Wanted levels in, pin levels out
  input  wire tsbg_pins_t want,
  output tsbg_pins_t      pins
);
  tsbg_pins_t lv  = '1;
  int         age = 24;
  assign pins = lv;
  // Two machine cycles per level, else the edge detector misses edges
  always @(posedge mclk) begin
    if (want != lv && age >= 24) begin
      lv  <= want;
      age <= 0;
    end else begin
      age <= age + 1;
    end
  end
endmodule : tsbg_pin_model

// ===== tsbg_test.sv
// Self-checking bench for the timer and baud block
`timescale 1ns/10ps
module tsbg_test;
  import tsbg_pkg::*;
  logic        mclk, arst_n, awv, wv, arv, bready, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdata, v, rnd;
  logic [1:0]  bresp, rresp, r;
  tsbg_pins_t  want, pins;
  tsbg_baud_t  baud;
  int          bad_count, checks, cyc, n, hi;
  logic [3:0]  sc [6] = '{4'h0, 4'h6, 4'h9, 4'hF, 4'h1, 4'h2};
  logic [9:0]  br [6] = '{10'h0, 10'h0, 10'h3FF, 10'h3FE, 10'h0, 10'h0};
  logic [5:0]  ax [6] = '{6'h0, 6'h0, 6'h0, 6'h0, 6'h14, 6'h0};
  tsbg_pin_model pm (.mclk(mclk), .want(want), .pins(pins));
  tsbg_top dut (
    .mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins),
    .baud(baud), .irq(irq)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int per(input logic [3:0] s, input logic [9:0] b, input logic [5:0] a);
    if (s[1:0] == 2'h0) return 12;
    if (s[1:0] == 2'h2) return s[2] ? 32 : 64;
    if (a[4]) return 32 * (32'h10000 - 32'hFFFE);
    return (s[2] ? 32 : 64) * (1024 - b);
  endfunction : per
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // Both channels offered together; the slave raises both readies when idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa    <= a;
    wd     <= d;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    do @(posedge mclk); while (awready !== 1'b1 || wready !== 1'b1);
    awv <= 1'b0;
    wv  <= 1'b0;
    do @(posedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    ara    <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arv <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask : rd
  task automatic tick_gap();
    do @(posedge mclk); while (baud.tx_tick !== 1'b1);
    n  = 0;
    hi = 0;
    do begin
      @(posedge mclk);
      n++;
      hi += baud.shift_clk;
    end while (baud.tx_tick !== 1'b1);
  endtask : tick_gap
  task automatic complete_run();
    $display("checks %0d, bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    {arst_n, awv, wv, arv, bready, rready, awa, ara, wd} = '0;
    want = '1;
    rnd  = 32'h5833;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    for (int a = 0; a <= 48; a += 4) begin
      rd(8'(a));
      chk(v, 32'h0);
      chk({30'h0, r}, (a == 48) ? 32'h2 : 32'h0);
    end
    repeat (3) begin
      rnd = lfsr(rnd);
      wr(8'h24, rnd);
      rd(8'h24);
      chk(v, {22'h0, rnd[9:0]});
    end
    wr(8'h08, 32'hFFF0);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h1);
    repeat (170) @(posedge mclk);
    rd(8'h28);
    chk(v[0], 1'b0);
    repeat (40) @(posedge mclk);
    chk(irq, 1'b0);
    wr(8'h2C, 32'h1);
    chk(irq, 1'b1);
    rd(8'h28);
    chk(v, 32'h1);
    chk(irq, 1'b0);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h9);
    want.ext_irq_zero_pin <= 1'b0;
    repeat (30) @(posedge mclk);
    wr(8'h04, 32'h1);
    repeat (100) @(posedge mclk);
    rd(8'h08);
    chk(v, 32'h0);
    want.ext_irq_zero_pin <= 1'b1;
    repeat (125) @(posedge mclk);
    rd(8'h08);
    chk(32'(v >= 8 && v <= 11), 32'h1);
    wr(8'h00, 32'h5);
    wr(8'h08, 32'h0);
    repeat (6) begin
      want.count_input_zero <= 1'b0;
      repeat (30) @(posedge mclk);
      want.count_input_zero <= 1'b1;
      repeat (30) @(posedge mclk);
    end
    rd(8'h08);
    chk(v, 32'h6);
    wr(8'h18, 32'hFFFE);
    wr(8'h1C, 32'hFFFE);
    for (int i = 0; i < 6; i++) begin
      wr(8'h10, {26'h0, ax[i]});
      wr(8'h24, {22'h0, br[i]});
      wr(8'h20, {28'h0, sc[i]});
      tick_gap();
      tick_gap();
      chk(32'(n), 32'(per(sc[i], br[i], ax[i])));
      chk(baud.frame_bits, sc[i][1] ? 4'hB : (sc[i][0] ? 4'hA : 4'h8));
      chk(32'(hi), (sc[i][1:0] == 2'h0) ? 32'h6 : 32'h0);
      if (!sc[i][0]) chk(baud.rx_tick, 1'b1);
    end
    rd(8'h28);
    chk(v[2], 1'b0);
    want.aux_ext_pin <= 1'b0;
    wr(8'h14, 32'h1);
    wr(8'h1C, 32'h10);
    wr(8'h10, 32'h4);
    chk({30'h0, r}, 32'h0);
    repeat (100) @(posedge mclk);
    rd(8'h1C);
    chk(32'(v == 32'h7 || v == 32'h8), 32'h1);
    wr(8'h30, 32'h0);
    chk({30'h0, r}, 32'h2);
    complete_run();
  end
endmodule : tsbg_test
